// ==== core/csr_defines.svh ====
// Purpose: Constants for the clock switch and reference output block
// Assumes: 16-bit oscillator control register split in two byte lanes
// Notes:   Field positions follow the control register layouts
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

`define CSR_KEY_HI_1      8'h78
`define CSR_KEY_HI_2      8'h9A
`define CSR_KEY_LO_1      8'h46
`define CSR_KEY_LO_2      8'h57
`define CSR_SWREQ_BIT     0
`define CSR_NOSC_LSB      8
`define CSR_NOSC_MSB      10
`define CSR_NOSC_RST      3'h0
`define CSR_REF_OUT_ENABLE_BIT      15
`define CSR_ROSLP_BIT     13
`define CSR_REF_SOURCE_SELECT_BIT     12
`define CSR_REF_OUT_DIVIDER_MSB     11
`define CSR_REF_OUT_DIVIDER_LSB     8
`define CSR_REFCTL_RST    16'h0000
`define CSR_DIV_W         15
`define CSR_DIV_ONE       15'h0001
`define CSR_DIV_ZERO      15'h0000

`endif

// ==== core/csr_pkg.sv ====
// Purpose: Types for the clock switch and reference output block
// Assumes: Nothing beyond the defines header
// Notes:   Unlock tracker states
package csr_pkg;
  typedef enum logic [1:0] {
    CSR_LK_IDLE = 2'b00,
    CSR_LK_KEY1 = 2'b01,
    CSR_LK_OPEN = 2'b10
  } csr_lock_t;
endpackage

// ==== core/csr_unlock.sv ====
// Purpose: Two-key unlock tracker for one byte of the oscillator control register
// Assumes: One write strobe per instruction; other instructions pulse instr_done
// Notes:   Window lasts exactly one instruction after the second key
`timescale 1ns/100ps
module csr_unlock
  import csr_pkg::*;
#(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Byte access
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic       instr_done,
  // Status
  output logic            open_now
);
  csr_lock_t state;
  csr_lock_t next_state;

  assign open_now = (state == CSR_LK_OPEN);

  always_comb begin
    next_state = state;
    case (state)
      CSR_LK_IDLE: begin
        if (wr && wdata == KEY1) next_state = CSR_LK_KEY1;
      end
      CSR_LK_KEY1: begin
        if (wr && wdata == KEY2) next_state = CSR_LK_OPEN;
        else if (wr && wdata == KEY1) next_state = CSR_LK_KEY1;
        else if (wr || instr_done) next_state = CSR_LK_IDLE;
      end
      CSR_LK_OPEN: begin
        // Any instruction closes the window
        if (wr || instr_done) next_state = CSR_LK_IDLE;
      end
      default: next_state = CSR_LK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) state <= CSR_LK_IDLE;
    else state <= next_state;
  end
endmodule

// ==== core/csr_clock_switch.sv ====
// Purpose: Oscillator control unlock, clock switch request, reference clock output
// Assumes: Writes are byte strobes, one per instruction; clocks sampled on core_clk
// Notes:   Reference output is built as a divided enable-domain square wave
//          Divider ratio n gives a period of 2 to the n source periods
//          An unlock window closes on any instruction, a write to the other byte too
//
// How it works
// - High byte takes new source only after keys 78h then 9Ah back to back.
// - Low byte unlocks only by keys 46h then 57h back to back.
// - Switch request clears on success; stays set on failure, lock shows cause.
// - Cycle clock pin shows oscillator divided by two in certain modes.
// - Reference output works in every oscillator configuration.
// - Output enable bit 15 routes divided reference onto reference pin.
// - Divider field bits 11:8 picks one of 16 ratios.
// - Source select picks primary crystal or system clock; bit 12.
// - Sleep-run bit keeps reference running during sleep only when source select picks the crystal.
// - Without source select the primary crystal powers down in sleep.
// - Source select clear makes reference follow the system clock.
`timescale 1ns/100ps
`include "csr_defines.svh"
module csr_clock_switch
  import csr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Oscillator control register byte writes
  input  wire logic        osc_hi_wr,
  input  wire logic        osc_lo_wr,
  input  wire logic [7:0]  osc_wdata,
  input  wire logic        instr_done,
  // Reference output control register write
  input  wire logic        refctl_wr,
  input  wire logic [15:0] refctl_wdata,
  // Oscillator status from the clock plant
  input  wire logic        switch_done,
  input  wire logic        pll_lock,
  input  wire logic        primary_mode,
  input  wire logic        cycle_clk_mode,
  input  wire logic        sleep_mode,
  // Clock sources, synchronous samples
  input  wire logic        primary_crystal_in,
  input  wire logic        system_clk_in,
  input  wire logic        fosc_in,
  // Register readback
  output logic [2:0]       new_source_select,
  output logic             switch_request,
  output logic             lock_status,
  output logic [15:0]      reference_output_control,
  // Pins and oscillator control
  output logic             ref_clock_pin,
  output logic             cycle_clock_pin,
  output logic             primary_crystal_out,
  output logic             primary_osc_enable,
  output logic             switch_start
);
  logic hi_open;
  logic lo_open;
  logic hi_other;
  logic lo_other;
  logic hi_take;
  logic swreq_set;

  logic                  ref_en;
  logic                  ref_slp;
  logic                  ref_sel;
  logic [3:0]            ref_div;
  logic                  ref_src;
  logic                  ref_src_d;
  logic                  ref_edge;
  logic                  ref_run;
  logic [`CSR_DIV_W-1:0] div_cnt;
  logic [`CSR_DIV_W-1:0] div_lim;
  logic                  div_q;
  logic                  fosc_q;
  logic                  div_wrap;

  // Any instruction that is not a write to this byte closes its unlock window,
  // so a key pair can never be split by a write to the other byte
  assign hi_other = instr_done || osc_lo_wr || refctl_wr;
  assign lo_other = instr_done || osc_hi_wr || refctl_wr;

  csr_unlock #(
    .KEY1 (`CSR_KEY_HI_1),
    .KEY2 (`CSR_KEY_HI_2)
  ) u_hi_lock (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .wr         (osc_hi_wr),
    .wdata      (osc_wdata),
    .instr_done (hi_other),
    .open_now   (hi_open)
  );

  csr_unlock #(
    .KEY1 (`CSR_KEY_LO_1),
    .KEY2 (`CSR_KEY_LO_2)
  ) u_lo_lock (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .wr         (osc_lo_wr),
    .wdata      (osc_wdata),
    .instr_done (lo_other),
    .open_now   (lo_open)
  );

  // A high-byte write lands only while its window is open
  assign hi_take = osc_hi_wr && hi_open;

  // New source select accepted only in the open window
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      new_source_select <= `CSR_NOSC_RST;
    end else if (hi_take) begin
      new_source_select <= osc_wdata[`CSR_NOSC_MSB-`CSR_NOSC_LSB:0];
    end
  end

  // A low-byte write with the request bit set, inside its open window
  assign swreq_set = osc_lo_wr && lo_open && osc_wdata[`CSR_SWREQ_BIT];

  // Switch request: set through low unlock, cleared by the plant on success
  // A new request wins over a success report in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      switch_request <= 1'b0;
    end else if (swreq_set) begin
      switch_request <= 1'b1;
    end else if (switch_done && switch_request) begin
      switch_request <= 1'b0;
    end
  end

  // One-cycle launch pulse to the clock plant
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      switch_start <= 1'b0;
    end else begin
      switch_start <= swreq_set;
    end
  end

  // Lock status lets software tell why a switch failed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_status <= 1'b0;
    end else begin
      lock_status <= pll_lock;
    end
  end

  // Reference control fields, one register each
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_en <= 1'b0;
    end else if (refctl_wr) begin
      ref_en <= refctl_wdata[`CSR_REF_OUT_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_slp <= 1'b0;
    end else if (refctl_wr) begin
      ref_slp <= refctl_wdata[`CSR_ROSLP_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_sel <= 1'b0;
    end else if (refctl_wr) begin
      ref_sel <= refctl_wdata[`CSR_REF_SOURCE_SELECT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_div <= 4'h0;
    end else if (refctl_wr) begin
      ref_div <= refctl_wdata[`CSR_REF_OUT_DIVIDER_MSB:`CSR_REF_OUT_DIVIDER_LSB];
    end
  end

  // Readback shows the fields; unimplemented bits read as zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) reference_output_control <= `CSR_REFCTL_RST;
    else begin
      reference_output_control <= `CSR_REFCTL_RST;
      reference_output_control[`CSR_REF_OUT_ENABLE_BIT]                 <= ref_en;
      reference_output_control[`CSR_ROSLP_BIT]                <= ref_slp;
      reference_output_control[`CSR_REF_SOURCE_SELECT_BIT]                <= ref_sel;
      reference_output_control[`CSR_REF_OUT_DIVIDER_MSB:`CSR_REF_OUT_DIVIDER_LSB] <= ref_div;
    end
  end

  // Source choice works whatever the system clock source is
  assign ref_src  = ref_sel ? primary_crystal_in : system_clk_in;
  assign ref_edge = ref_src && !ref_src_d;
  // In sleep the output runs only with sleep-run and crystal source
  assign ref_run  = ref_en && (!sleep_mode || (ref_slp && ref_sel));

  // Ratio 0 passes the source; ratio n toggles every 2 to the n-1 source edges.
  // Shifting by n-1 keeps the largest ratio inside the counter width.
  always_comb begin
    div_lim = `CSR_DIV_ONE;
    if (ref_div != 4'h0) begin
      div_lim = `CSR_DIV_ONE << (ref_div - 4'h1);
    end
  end

  // Previous source sample; resets to the idle low level so no false edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_src_d <= 1'b0;
    end else begin
      ref_src_d <= ref_src;
    end
  end

  // Wrap when the edge count reaches the limit of 2 to the n-1 edges
  assign div_wrap = ref_edge && (ref_div != 4'h0) && (div_cnt + `CSR_DIV_ONE >= div_lim);

  // Divider counter restarts whenever the output is stopped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt <= `CSR_DIV_ZERO;
    end else if (!ref_run) begin
      div_cnt <= `CSR_DIV_ZERO;
    end else if (div_wrap) begin
      div_cnt <= `CSR_DIV_ZERO;
    end else if (ref_edge && ref_div != 4'h0) begin
      div_cnt <= div_cnt + `CSR_DIV_ONE;
    end
  end

  // Divided output toggles once per wrap
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q <= 1'b0;
    end else if (!ref_run) begin
      div_q <= 1'b0;
    end else if (div_wrap) begin
      div_q <= !div_q;
    end
  end

  // Pin parks low whenever stopped, so a restart begins from a known level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_clock_pin <= 1'b0;
    end else if (!ref_run) begin
      ref_clock_pin <= 1'b0;
    end else if (ref_div == 4'h0) begin
      ref_clock_pin <= ref_src;
    end else begin
      ref_clock_pin <= div_q;
    end
  end

  // Previous oscillator sample for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fosc_q <= 1'b0;
    end else begin
      fosc_q <= fosc_in;
    end
  end

  // Cycle clock pin: Fosc halved on each rising oscillator sample,
  // parked low while the cycle clock mode is off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cycle_clock_pin <= 1'b0;
    end else if (!cycle_clk_mode) begin
      cycle_clock_pin <= 1'b0;
    end else if (fosc_in && !fosc_q) begin
      cycle_clock_pin <= !cycle_clock_pin;
    end
  end

  // Primary crystal powers down in sleep unless it feeds the reference
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_osc_enable <= 1'b0;
    end else begin
      primary_osc_enable <= primary_mode && (!sleep_mode || ref_sel);
    end
  end

  // Crystal drive is the inverted input while the oscillator is enabled
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      primary_crystal_out <= 1'b0;
    end else begin
      primary_crystal_out <= primary_osc_enable && primary_mode && !primary_crystal_in;
    end
  end
endmodule

// ==== tb/csr_checker.sv ====
// Purpose: Port checks for csr_clock_switch
// Assumes: Write strobes last one cycle
// Notes:   Bound to every instance below
`timescale 1ns/100ps
module csr_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Inputs
  input wire logic        osc_hi_wr,
  input wire logic        osc_lo_wr,
  input wire logic [7:0]  osc_wdata,
  input wire logic        switch_done,
  input wire logic        pll_lock,
  input wire logic        sleep_mode,
  input wire logic        primary_crystal_in,
  input wire logic        system_clk_in,
  // Outputs
  input wire logic [2:0]  new_source_select,
  input wire logic        switch_request,
  input wire logic        switch_start,
  input wire logic        lock_status,
  input wire logic [15:0] reference_output_control,
  input wire logic        ref_clock_pin
);
  logic [15:0] rc;
  logic        src;
  assign rc = reference_output_control;
  assign src = rc[12] ? primary_crystal_in : system_clk_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence hi_keys;
    osc_hi_wr && osc_wdata == 8'h78 ##1 osc_hi_wr && osc_wdata == 8'h9A;
  endsequence
  sequence lo_keys;
    osc_lo_wr && osc_wdata == 8'h46 ##1 osc_lo_wr && osc_wdata == 8'h57;
  endsequence
  hi_open_a: assert property (hi_keys ##1 osc_hi_wr |=>
    new_source_select == $past(osc_wdata[2:0])) else $error("source not taken");
  hi_lock_a: assert property (!$stable(new_source_select) |->
    $past(osc_hi_wr) && $past(osc_hi_wr, 2) && $past(osc_hi_wr, 3) &&
    $past(osc_wdata, 2) == 8'h9A && $past(osc_wdata, 3) == 8'h78)
    else $error("source changed while locked");
  lo_open_a: assert property (lo_keys ##1 osc_lo_wr && osc_wdata[0] |=>
    switch_request && switch_start) else $error("switch not requested");
  req_lock_a: assert property ($rose(switch_request) |->
    $past(osc_lo_wr) && $past(osc_lo_wr, 2) && $past(osc_lo_wr, 3) &&
    $past(osc_wdata, 2) == 8'h57 && $past(osc_wdata, 3) == 8'h46)
    else $error("request set while locked");
  start_one_a: assert property (switch_start |->
    $rose(switch_request) ##1 !switch_start) else $error("bad start pulse");
  done_clr_a: assert property (switch_done && !osc_lo_wr |=>
    !switch_request) else $error("request not cleared");
  fail_hold_a: assert property (switch_request && !switch_done && !osc_lo_wr |=>
    switch_request) else $error("request dropped");
  lock_copy_a: assert property (1'b1 |=> lock_status == $past(pll_lock))
    else $error("lock status wrong");
  ref_off_a: assert property (!rc[15] [*2] |-> !ref_clock_pin)
    else $error("pin active while disabled");
  div_zero_a: assert property ((rc[15] && rc[11:8] == 4'h0 && !sleep_mode) [*2] |->
    ref_clock_pin == $past(src)) else $error("pin not source");
  sleep_off_a: assert property ((sleep_mode && !(rc[13] && rc[12])) [*2] |->
    !ref_clock_pin) else $error("pin active in sleep");
  cover property (hi_keys ##1 osc_hi_wr);
  cover property (switch_start);
  cover property (sleep_mode && ref_clock_pin);
endmodule

bind csr_clock_switch csr_checker i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .osc_hi_wr(osc_hi_wr), .osc_lo_wr(osc_lo_wr),
  .osc_wdata(osc_wdata), .switch_done(switch_done), .pll_lock(pll_lock),
  .sleep_mode(sleep_mode), .primary_crystal_in(primary_crystal_in),
  .system_clk_in(system_clk_in), .new_source_select(new_source_select),
  .switch_request(switch_request), .switch_start(switch_start),
  .lock_status(lock_status), .reference_output_control(reference_output_control),
  .ref_clock_pin(ref_clock_pin)
);

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for csr_clock_switch
// Assumes: Inputs change on the falling edge
// Notes:   Divider ratios are checked by counting pin toggles
`timescale 1ns/100ps
module tb_top;
  logic        core_clk, rst_n, osc_hi_wr, osc_lo_wr, instr_done, refctl_wr;
  logic        switch_done, pll_lock, primary_mode, cycle_clk_mode, sleep_mode;
  logic        primary_crystal_in, system_clk_in, fosc_in, switch_start;
  logic        switch_request, lock_status, ref_clock_pin, cycle_clock_pin;
  logic        primary_crystal_out, primary_osc_enable;
  logic [7:0]  osc_wdata;
  logic [2:0]  new_source_select;
  logic [15:0] refctl_wdata, reference_output_control;
  int          bad_count, total_checks;

  csr_clock_switch i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .osc_hi_wr(osc_hi_wr), .osc_lo_wr(osc_lo_wr),
    .osc_wdata(osc_wdata), .instr_done(instr_done), .refctl_wr(refctl_wr),
    .refctl_wdata(refctl_wdata), .switch_done(switch_done), .pll_lock(pll_lock),
    .primary_mode(primary_mode), .cycle_clk_mode(cycle_clk_mode),
    .sleep_mode(sleep_mode), .primary_crystal_in(primary_crystal_in),
    .system_clk_in(system_clk_in), .fosc_in(fosc_in),
    .new_source_select(new_source_select), .switch_request(switch_request),
    .lock_status(lock_status), .reference_output_control(reference_output_control),
    .ref_clock_pin(ref_clock_pin), .cycle_clock_pin(cycle_clock_pin),
    .primary_crystal_out(primary_crystal_out),
    .primary_osc_enable(primary_osc_enable), .switch_start(switch_start)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Kind 0 other instruction, 1 high byte, 2 low byte, 3 reference control
  task automatic wr(logic [1:0] k, logic [15:0] d);
    instr_done = k == 2'd0;
    osc_hi_wr = k == 2'd1;
    osc_lo_wr = k == 2'd2;
    refctl_wr = k == 2'd3;
    osc_wdata = d[7:0];
    refctl_wdata = d;
    @(negedge core_clk);
  endtask

  task automatic nop();
    {instr_done, osc_hi_wr, osc_lo_wr, refctl_wr} = 4'h0;
    @(negedge core_clk);
  endtask

  // Toggles one source and fosc each cycle, then counts pin changes over 40 cycles
  task automatic run(bit s, int e);
    int n, m;
    logic p, c;
    n = 0;
    m = 0;
    for (int i = 0; i < 56; i++) begin
      p = ref_clock_pin;
      c = cycle_clock_pin;
      if (s) system_clk_in = ~system_clk_in;
      else primary_crystal_in = ~primary_crystal_in;
      fosc_in = ~fosc_in;
      @(negedge core_clk);
      if (i >= 16) n += int'(p !== ref_clock_pin);
      if (i >= 16) m += int'(c !== cycle_clock_pin);
    end
    chk("ref toggles", 16'(e), 16'(n));
    if (!sleep_mode) chk("cycle toggles", 16'd20, 16'(m));
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {instr_done, osc_hi_wr, osc_lo_wr, refctl_wr, switch_done, pll_lock} = 6'h00;
    {sleep_mode, primary_crystal_in, system_clk_in, fosc_in} = 4'h0;
    {primary_mode, cycle_clk_mode} = 2'h3;
    osc_wdata = 8'h00;
    refctl_wdata = 16'h0000;
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    chk("control", 16'h0000, reference_output_control);
    wr(2'd2, 16'h0001);
    nop();
    chk("request", 16'h0000, 16'(switch_request));
    wr(2'd1, 16'h0078); wr(2'd1, 16'h009A); wr(2'd1, 16'h0005); nop();
    chk("source", 16'h0005, 16'(new_source_select));
    wr(2'd1, 16'h0078); wr(2'd0, 16'h0000); wr(2'd1, 16'h009A); wr(2'd1, 16'h0006);
    wr(2'd1, 16'h0078); wr(2'd1, 16'h0011); wr(2'd1, 16'h009A); wr(2'd1, 16'h0006);
    wr(2'd1, 16'h0078); wr(2'd1, 16'h009A); wr(2'd0, 16'h0000); wr(2'd1, 16'h0006);
    wr(2'd1, 16'h0078); wr(2'd1, 16'h009A); wr(2'd2, 16'h0000); wr(2'd1, 16'h0006);
    nop();
    chk("source", 16'h0005, 16'(new_source_select));
    wr(2'd2, 16'h0046); wr(2'd2, 16'h0057); wr(2'd2, 16'h0001);
    chk("start", 16'h0001, 16'(switch_start));
    pll_lock = 1'b1;
    repeat (3) nop();
    chk("start", 16'h0000, 16'(switch_start));
    chk("request", 16'h0001, 16'(switch_request));
    chk("lock", 16'h0001, 16'(lock_status));
    switch_done = 1'b1;
    nop();
    switch_done = 1'b0;
    nop();
    chk("request", 16'h0000, 16'(switch_request));
    wr(2'd3, 16'hFFFF); nop();
    chk("control", 16'hBF00, reference_output_control);
    for (int d = 0; d < 4; d++) begin
      wr(2'd3, 16'h9000 | 16'(d << 8)); nop();
      run(1'b0, d == 0 ? 40 : 20 >> (d - 1));
    end
    wr(2'd3, 16'h8000); nop();
    run(1'b1, 40);
    sleep_mode = 1'b1;
    run(1'b1, 0);
    chk("osc enable", 16'h0000, 16'(primary_osc_enable));
    wr(2'd3, 16'hB000); nop();
    run(1'b0, 40);
    chk("osc enable", 16'h0001, 16'(primary_osc_enable));
    chk("crystal out", 16'(!primary_crystal_in), 16'(primary_crystal_out));
    cycle_clk_mode = 1'b0;
    primary_mode = 1'b0;
    nop();
    chk("cycle pin", 16'h0000, 16'(cycle_clock_pin));
    chk("osc enable", 16'h0000, 16'(primary_osc_enable));
    // Reset in mid-run with a switch request pending
    wr(2'd2, 16'h0046); wr(2'd2, 16'h0057); wr(2'd2, 16'h0001);
    rst_n = 1'b0;
    repeat (2) nop();
    rst_n = 1'b1;
    chk("request", 16'h0000, 16'(switch_request));
    chk("source", 16'h0000, 16'(new_source_select));
    chk("control", 16'h0000, reference_output_control);
    finish_test();
  end
endmodule
